// ### inc/hkadc_defines.svh
// Register offsets, field positions, reset values and timing for the housekeeping converter block.
// Assumes an 8-bit register port with byte addresses.
`ifndef HKADC_DEFINES_SVH
`define HKADC_DEFINES_SVH
`define HK_A_TEMP_RES     8'hD7
`define HK_A_CONV_START   8'hD8
`define HK_A_BATT_RES     8'hDF
`define HK_A_PWR_EN       8'hEC
`define HK_A_EXT_RES      8'hEF
`define HK_A_DELTA_CFG    8'hF3
`define HK_A_PERIPHERAL_CONFIG_CFG   8'hF4
`define HK_A_PWR_FLAGS    8'hF8
`define HK_A_STROBE_CFG   8'hF9
`define HK_A_BATT_THR     8'hFA
`define HK_B_BATT_GO      0
`define HK_B_TEMP_GO      1
`define HK_B_EXT_GO       2
`define HK_B_LOCK_ACK     7
`define HK_B_LOW_BATT     2
`define HK_B_LOCK_FAULT   4
`define HK_F_TEMP_PER     1:0
`define HK_F_BATT_PER     3:2
`define HK_F_EXT_PER      5:4
`define HK_F_TEMP_DELTA   5:3
`define HK_STROBE_MASK    8'h3F
`define HK_DELTA_MASK     8'h3F
`define HK_RST_BYTE       8'h00
`define HK_DELTA_ALL      3'h7
`define HK_DELTA_NONE     3'h0
`define HK_PER_OFF        2'h0
`define HK_PER_LONG       2'h1
`define HK_PER_MID        2'h2
`define HK_PER_SHORT      2'h3
`define HK_CLK_HZ         32'h02FAF080
`define HK_MIN_S          32'h0000003C
`define HK_MINUTE_CYC     (`HK_CLK_HZ * `HK_MIN_S)
`define HK_MIN_W          5
`endif

// ### inc/hkadc_pkg.sv
// Types shared by the housekeeping converter block.
// Assumes nothing outside itself.
package hkadc_pkg;
  typedef enum logic [1:0] {
    HKADC_CH_BATT,
    HKADC_CH_TEMP,
    HKADC_CH_EXT
  } hkadc_ch_t;
  typedef enum logic [1:0] {
    HKADC_MODE_FULL,
    HKADC_MODE_BATT,
    HKADC_MODE_SLEEP
  } hkadc_mode_t;
endpackage

// ### inc/hkadc_tick_if.sv
// Carries the minute tick between the timebase and the controller.
// Assumes one clock.
`timescale 1ns/1ps
interface hkadc_tick_if;
  logic minute_tick;
  modport src (output minute_tick);
  modport dst (input minute_tick);
endinterface

// ### src/hkadc_ctrl.sv
// Housekeeping converter control: request bits, schedules, result registers and tests.
// Assumes a synchronous 8-bit register port and an external converter with req/ack/done.
`timescale 1ns/1ps
`include "hkadc_defines.svh"
module hkadc_ctrl #(
  parameter int unsigned MINUTE_CYCLES = `HK_MINUTE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  output logic [7:0]      reg_rdata_o,
  input  wire logic       full_power_mode_i,
  input  wire logic       battery_run_mode_i,
  input  wire logic       sleep_mode_i,
  input  wire logic       lock_loss_reset_i,
  output logic            conv_req_o,
  output logic [1:0]      conv_ch_o,
  input  wire logic       conv_ack_i,
  input  wire logic       conv_done_i,
  input  wire logic [7:0] conv_data_i,
  output logic            conv_irq_o,
  output logic            power_irq_o,
  output logic            lock_fault_flag_o
);
  typedef struct packed {
    logic [2:0]  go;
    logic        bg_temp;
    logic        bg_batt;
    logic        bg_ext;
    logic        busy;
    logic        single;
    logic [1:0]  ch;
    logic        req;
    logic [7:0]  temp_res;
    logic [7:0]  batt_res;
    logic [7:0]  ext_res;
    logic [7:0]  temp_ref;
    logic [7:0]  delta_cfg;
    logic [7:0]  strobe_cfg;
    logic [7:0]  batt_thr;
    logic [7:0]  pwr_flags;
    logic [7:0]  pwr_en;
    logic        lock_fault;
    logic        conv_irq;
    logic        power_irq;
    logic [7:0]  rdata;
    logic [2:0]  mode_s1;
    logic [2:0]  mode_s2;
  } hkadc_state_t;
  hkadc_state_t s_q;
  hkadc_state_t s_d;

  hkadc_tick_if tick_if ();
  logic        due_temp;
  logic        due_batt;
  logic        full_m;
  logic        sleep_m;
  logic        wr_start;
  logic [7:0]  diff;
  logic [2:0]  tdelta;
  logic        bat_low;

  // ----------------------------------------
  // Timebase and schedules
  // ----------------------------------------
  hkadc_timebase #(
    .MINUTE_CYCLES (MINUTE_CYCLES)
  ) u_timebase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tick  (tick_if.src)
  );

  hkadc_sched #(
    .LONG_MIN  (5'h08),
    .MID_MIN   (5'h02),
    .SHORT_MIN (5'h01)
  ) u_sched_temp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick_if.minute_tick),
    .period_i (s_q.strobe_cfg[`HK_F_TEMP_PER]),
    .allow_i  (full_m | sleep_m),
    .due_o    (due_temp)
  );

  hkadc_sched #(
    .LONG_MIN  (5'h10),
    .MID_MIN   (5'h04),
    .SHORT_MIN (5'h01)
  ) u_sched_batt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick_if.minute_tick),
    .period_i (s_q.strobe_cfg[`HK_F_BATT_PER]),
    .allow_i  (full_m),
    .due_o    (due_batt)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign full_m   = s_q.mode_s2[0];
  assign sleep_m  = s_q.mode_s2[2];
  assign wr_start = reg_wr_i && reg_addr_i == `HK_A_CONV_START;
  assign tdelta   = s_q.delta_cfg[`HK_F_TEMP_DELTA];
  assign diff     = (conv_data_i > s_q.temp_ref) ? conv_data_i - s_q.temp_ref
                                                 : s_q.temp_ref - conv_data_i;
  assign bat_low  = conv_data_i < s_q.batt_thr;

  always_comb
  begin
    s_d = s_q;
    s_d.mode_s1   = {sleep_mode_i, battery_run_mode_i, full_power_mode_i};
    s_d.mode_s2   = s_q.mode_s1;
    s_d.conv_irq  = 1'b0;
    s_d.power_irq = |(s_q.pwr_flags & s_q.pwr_en & (8'h01 << `HK_B_LOW_BATT));
    if (due_temp)
    begin
      s_d.bg_temp = 1'b1;
    end
    if (due_batt)
    begin
      s_d.bg_batt = 1'b1;
    end
    // Register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `HK_A_TEMP_RES:   s_d.temp_res   = reg_wdata_i;
        `HK_A_BATT_RES:   s_d.batt_res   = reg_wdata_i;
        `HK_A_EXT_RES:    s_d.ext_res    = reg_wdata_i;
        `HK_A_DELTA_CFG:  s_d.delta_cfg  = reg_wdata_i & `HK_DELTA_MASK;
        `HK_A_STROBE_CFG: s_d.strobe_cfg = reg_wdata_i & `HK_STROBE_MASK;
        `HK_A_BATT_THR:   s_d.batt_thr   = reg_wdata_i;
        `HK_A_PWR_EN:     s_d.pwr_en     = reg_wdata_i;
        `HK_A_PWR_FLAGS:  s_d.pwr_flags  = s_q.pwr_flags & ~reg_wdata_i;
        default:          s_d.rdata      = s_d.rdata;
      endcase
    end
    if (wr_start)
    begin
      if (!sleep_m)
      begin
        s_d.go = s_q.go | reg_wdata_i[`HK_B_EXT_GO:`HK_B_BATT_GO];
      end
      if (reg_wdata_i[`HK_B_LOCK_ACK])
      begin
        s_d.lock_fault = 1'b0;
      end
    end
    if (lock_loss_reset_i)
    begin
      s_d.lock_fault = 1'b1;
    end
    // Arbiter: battery, temperature, external
    if (!s_q.busy)
    begin
      if (s_q.go[`HK_B_BATT_GO] && !sleep_m)
      begin
        s_d.busy = 1'b1; s_d.req = 1'b1; s_d.single = 1'b1;
        s_d.ch   = hkadc_pkg::HKADC_CH_BATT;
      end
      else if (s_q.go[`HK_B_TEMP_GO] && !sleep_m)
      begin
        s_d.busy = 1'b1; s_d.req = 1'b1; s_d.single = 1'b1;
        s_d.ch   = hkadc_pkg::HKADC_CH_TEMP;
      end
      else if (s_q.go[`HK_B_EXT_GO] && !sleep_m)
      begin
        s_d.busy = 1'b1; s_d.req = 1'b1; s_d.single = 1'b1;
        s_d.ch   = hkadc_pkg::HKADC_CH_EXT;
      end
      else if (s_q.bg_batt && full_m)
      begin
        s_d.busy = 1'b1; s_d.req = 1'b1; s_d.single = 1'b0;
        s_d.ch   = hkadc_pkg::HKADC_CH_BATT;
      end
      else if (s_q.bg_temp && (full_m || sleep_m))
      begin
        s_d.busy = 1'b1; s_d.req = 1'b1; s_d.single = 1'b0;
        s_d.ch   = hkadc_pkg::HKADC_CH_TEMP;
      end
    end
    else if (s_q.req && conv_ack_i)
    begin
      s_d.req = 1'b0;
      if (s_q.single)
      begin
        s_d.go[s_q.ch] = wr_start && !sleep_m && reg_wdata_i[s_q.ch];
      end
      else if (s_q.ch == hkadc_pkg::HKADC_CH_BATT)
      begin
        s_d.bg_batt = due_batt;
      end
      else
      begin
        s_d.bg_temp = due_temp;
      end
    end
    else if (!s_q.req && conv_done_i)
    begin
      s_d.busy = 1'b0;
      case (s_q.ch)
        hkadc_pkg::HKADC_CH_TEMP:
        begin
          if (s_q.single || (tdelta != `HK_DELTA_NONE
              && (tdelta == `HK_DELTA_ALL || diff > {5'h00, tdelta})))
          begin
            s_d.temp_res = conv_data_i;
            s_d.temp_ref = conv_data_i;
            s_d.conv_irq = 1'b1;
          end
        end
        hkadc_pkg::HKADC_CH_BATT:
        begin
          if (s_q.single || bat_low)
          begin
            s_d.batt_res = conv_data_i;
            s_d.conv_irq = 1'b1;
          end
          if (bat_low)
          begin
            s_d.pwr_flags[`HK_B_LOW_BATT] = 1'b1;
          end
        end
        hkadc_pkg::HKADC_CH_EXT:
        begin
          s_d.ext_res  = conv_data_i;
          s_d.conv_irq = 1'b1;
        end
        default:
        begin
          s_d.busy = 1'b0;
        end
      endcase
    end
    // Read data
    case (reg_addr_i)
      `HK_A_TEMP_RES:   s_d.rdata = s_d.temp_res;
      `HK_A_CONV_START: s_d.rdata = {5'h00, s_d.go};
      `HK_A_BATT_RES:   s_d.rdata = s_d.batt_res;
      `HK_A_EXT_RES:    s_d.rdata = s_d.ext_res;
      `HK_A_DELTA_CFG:  s_d.rdata = s_d.delta_cfg;
      `HK_A_STROBE_CFG: s_d.rdata = s_d.strobe_cfg;
      `HK_A_BATT_THR:   s_d.rdata = s_d.batt_thr;
      `HK_A_PWR_FLAGS:  s_d.rdata = s_d.pwr_flags;
      `HK_A_PWR_EN:     s_d.rdata = s_d.pwr_en;
      `HK_A_PERIPHERAL_CONFIG_CFG: s_d.rdata = {3'h0, s_d.lock_fault, 4'h0};
      default:          s_d.rdata = `HK_RST_BYTE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o       = s_q.rdata;
  assign conv_req_o        = s_q.req;
  assign conv_ch_o         = s_q.ch;
  assign conv_irq_o        = s_q.conv_irq;
  assign power_irq_o       = s_q.power_irq;
  assign lock_fault_flag_o = s_q.lock_fault;
endmodule

// ### src/hkadc_sched.sv
// Background interval counter for one channel, counting minute ticks.
// Assumes a one-cycle minute tick and a two-bit interval code.
`timescale 1ns/1ps
`include "hkadc_defines.svh"
module hkadc_sched #(
  parameter logic [4:0] LONG_MIN  = 5'h08,
  parameter logic [4:0] MID_MIN   = 5'h02,
  parameter logic [4:0] SHORT_MIN = 5'h01
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] period_i,
  input  wire logic       allow_i,
  output logic            due_o
);
  typedef struct packed {
    logic [4:0] mins;
    logic       due;
  } hkadc_sc_state_t;
  hkadc_sc_state_t s_q;
  hkadc_sc_state_t s_d;
  logic [4:0]      limit;

  always_comb
  begin
    case (period_i)
      `HK_PER_LONG:  limit = LONG_MIN;
      `HK_PER_MID:   limit = MID_MIN;
      `HK_PER_SHORT: limit = SHORT_MIN;
      default:       limit = 5'h00;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.due = 1'b0;
    if (period_i == `HK_PER_OFF || !allow_i)
    begin
      s_d.mins = 5'h00;
    end
    else if (tick_i)
    begin
      if (s_q.mins + 5'h01 >= limit)
      begin
        s_d.mins = 5'h00;
        s_d.due  = 1'b1;
      end
      else
      begin
        s_d.mins = s_q.mins + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign due_o = s_q.due;
endmodule

// ### src/hkadc_timebase.sv
// Minute tick generator for background conversion schedules.
// Assumes clk_i at the rate in the defines header.
`timescale 1ns/1ps
`include "hkadc_defines.svh"
module hkadc_timebase #(
  parameter int unsigned MINUTE_CYCLES = `HK_MINUTE_CYC
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  hkadc_tick_if.src  tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } hkadc_tb_state_t;
  hkadc_tb_state_t s_q;
  hkadc_tb_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= MINUTE_CYCLES - 1)
    begin
      s_d.cnt  = 32'h0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick.minute_tick = s_q.tick;
endmodule

// ### verification/hkadc_ctrl_properties.sv
// Port checker for the housekeeping converter control.
// Assumes it is bound to hkadc_ctrl on one clock.
`timescale 1ns/1ps
module hkadc_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       sleep_mode_i,
  input wire logic       lock_loss_reset_i,
  input wire logic       conv_req_o,
  input wire logic [1:0] conv_ch_o,
  input wire logic       conv_ack_i,
  input wire logic       conv_done_i,
  input wire logic       conv_irq_o,
  input wire logic       lock_fault_flag_o
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_drop;
    conv_req_o && conv_ack_i |=> !conv_req_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  property p_req_hold;
    conv_req_o && !conv_ack_i |=> conv_req_o && $stable(conv_ch_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request lost");
  property p_irq_pulse;
    conv_irq_o |=> !conv_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
  property p_irq_cause;
    conv_irq_o |-> $past(conv_done_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
  property p_lock_set;
    lock_loss_reset_i |=> lock_fault_flag_o;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("fault flag not set");
  property p_lock_clr;
    reg_wr_i && reg_addr_i == 8'hD8 && reg_wdata_i[7] && !lock_loss_reset_i
      |=> !lock_fault_flag_o;
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("fault flag not cleared");
  property p_sleep_batt;
    sleep_mode_i [*4] ##0 $rose(conv_req_o) |-> conv_ch_o != 2'h0;
  endproperty
  a_sleep_batt: assert property (p_sleep_batt) else $error("battery in sleep");
  property p_rd_start;
    reg_addr_i == 8'hD8 |=> reg_rdata_o[6:3] == 4'h0;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("start bits 6:3 set");
endmodule

bind hkadc_ctrl hkadc_props u_props (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rdata_o, .sleep_mode_i, .lock_loss_reset_i, .conv_req_o, .conv_ch_o, .conv_ack_i,
  .conv_done_i, .conv_irq_o, .lock_fault_flag_o);

// ### verification/tb_top.sv
// Bench for hkadc_ctrl: converter responder and result model.
// Assumes the checker is bound and a short minute count.
`timescale 1ns/1ps
module tb_top;
  logic       clk_i;
  logic       rst_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic [7:0] reg_rdata_o;
  logic       full_power_mode_i;
  logic       battery_run_mode_i;
  logic       sleep_mode_i;
  logic       lock_loss_reset_i;
  logic       conv_req_o;
  logic [1:0] conv_ch_o;
  logic       conv_ack_i;
  logic       conv_done_i;
  logic [7:0] conv_data_i;
  logic       conv_irq_o;
  logic       power_irq_o;
  logic       lock_fault_flag_o;
  int         n_errors = 0;
  int         total_checks = 0;
  int         go = 0;
  int         thr = 0;
  int         dlt = 0;
  int         ref_t = 0;
  int         flag = 0;
  int         en = 0;
  int         res [3] = '{0, 0, 0};
  logic       busy = 1'b0;
  logic [7:0] v;
  logic [7:0] ra [3] = '{8'hDF, 8'hD7, 8'hEF};
  logic [7:0] rl [7] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hFA, 8'hF9, 8'h00};
  int         offs [5] = '{2, 3, -3, 1, -2};
  int         dl [3] = '{0, 7, 1};
  int         cyc = 0;
  int         t_req = 0;
  int         t0 = 0;
  logic [7:0] gc [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
  int         gch [4] = '{0, 0, 1, 1};
  int         gm [4] = '{4, 16, 2, 8};
  localparam int MIN_CYC = 20;

  hkadc_ctrl #(.MINUTE_CYCLES(MIN_CYC)) dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rdata_o, .full_power_mode_i, .battery_run_mode_i, .sleep_mode_i,
    .lock_loss_reset_i, .conv_req_o, .conv_ch_o, .conv_ack_i, .conv_done_i, .conv_data_i,
    .conv_irq_o, .power_irq_o, .lock_fault_flag_o);

  // ----------------
  // Tasks
  // ----------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    reg_addr_i <= a;
    @(posedge clk_i);
    #1 q = reg_rdata_o;
  endtask
  task automatic serve(input int c, input logic [7:0] d, input bit sw);
    logic [7:0] q;
    int         i;
    int         df;
    bit         irq;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk_i);
      #1;
      if (conv_req_o === 1'b1)
        break;
    end
    if (i == 400)
    begin
      n_errors++;
      $display("Error conv_req_o exp 1 got 0");
      print_verdict();
    end
    t_req = cyc;
    chk("conv_ch_o", 8'(c), 8'(conv_ch_o));
    rd(8'hD8, q);
    chk("conv_start", 8'(go), q & 8'h07);
    @(posedge clk_i);
    conv_ack_i <= 1'b1;
    @(posedge clk_i);
    conv_ack_i  <= 1'b0;
    conv_done_i <= 1'b1;
    conv_data_i <= d;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    conv_data_i <= ~d;
    if (sw)
      go &= ~(1 << c);
    df = d > ref_t ? d - ref_t : ref_t - d;
    irq = sw || c == 2 || (c == 0 && d < thr);
    irq = irq || (c == 1 && (dlt == 7 || (dlt != 0 && df > dlt)));
    #1 chk("conv_irq_o", 8'(irq), 8'(conv_irq_o));
    if (irq)
      res[c] = d;
    if (irq && c == 1)
      ref_t = d;
    if (c == 0 && d < thr)
      flag = 1;
    rd(ra[c], q);
    chk("result", 8'(res[c]), q);
    chk("power_irq_o", 8'(flag & en), 8'(power_irq_o));
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
  end
  initial
  begin
    rst_i              = 1'b1;
    reg_addr_i         = 8'h00;
    reg_wdata_i        = 8'h00;
    reg_wr_i           = 1'b0;
    full_power_mode_i  = 1'b1;
    battery_run_mode_i = 1'b0;
    sleep_mode_i       = 1'b0;
    lock_loss_reset_i  = 1'b0;
    conv_ack_i         = 1'b0;
    conv_done_i        = 1'b0;
    conv_data_i        = 8'h00;
    void'($urandom(32'hB57A0EDD));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rl[i])
    begin
      rd(rl[i], v);
      chk("reset", 8'h00, v);
    end
    $display("t1 done");
    thr = 8'h80;
    wr(8'hFA, 8'h80);
    for (int c = 0; c < 3; c++)
    begin
      go = 1 << c;
      wr(8'hD8, 8'(go));
      serve(c, 8'($urandom), 1'b1);
    end
    for (int e = 0; e < 2; e++)
    begin
      en = e;
      wr(8'hEC, 8'(e << 2));
      go = 1;
      wr(8'hD8, 8'h01);
      serve(0, 8'($urandom % 128), 1'b1);
      rd(8'hF8, v);
      chk("low_battery_flag", 8'h04, v & 8'h04);
      wr(8'hF8, 8'h04);
      flag = 0;
    end
    $display("t2 done");
    go = 7;
    wr(8'hD8, 8'h07);
    for (int c = 0; c < 3; c++)
      serve(c, 8'($urandom), 1'b1);
    $display("t3 done");
    @(posedge clk_i);
    lock_loss_reset_i <= 1'b1;
    @(posedge clk_i);
    lock_loss_reset_i <= 1'b0;
    #1 chk("lock_fault_flag_o", 8'h01, 8'(lock_fault_flag_o));
    wr(8'hD8, 8'hF8);
    #1 chk("lock_fault_flag_o", 8'h00, 8'(lock_fault_flag_o));
    rd(8'hD8, v);
    chk("conv_start", 8'h00, v & 8'h7F);
    $display("t4 done");
    dlt = 2;
    wr(8'hF3, 8'h10);
    wr(8'hF9, 8'h03);
    foreach (offs[i])
      serve(1, 8'(ref_t + offs[i]), 1'b0);
    foreach (dl[i])
    begin
      dlt = dl[i];
      wr(8'hF3, 8'(dlt << 3));
      serve(1, 8'(ref_t + 1), 1'b0);
    end
    wr(8'hF9, 8'h0C);
    serve(0, 8'($urandom), 1'b0);
    foreach (gc[i])
    begin
      wr(8'hF9, gc[i]);
      serve(gch[i], 8'($urandom), 1'b0);
      t0 = t_req;
      serve(gch[i], 8'($urandom), 1'b0);
      chk("interval_min", 8'(gm[i]), 8'((t_req - t0) / MIN_CYC));
      chk("interval_rem", 8'h00, 8'((t_req - t0) % MIN_CYC));
    end
    $display("t5 done");
    wr(8'hF9, 8'h00);
    full_power_mode_i  <= 1'b0;
    battery_run_mode_i <= 1'b1;
    wr(8'hF9, 8'h0F);
    for (int i = 0; i < 70; i++)
    begin
      @(posedge clk_i);
      #1 busy |= conv_req_o;
    end
    chk("bg_request", 8'h00, 8'(busy));
    for (int c = 0; c < 2; c++)
    begin
      go = 1 << c;
      wr(8'hD8, 8'(go));
      serve(c, 8'($urandom), 1'b1);
    end
    @(posedge clk_i);
    battery_run_mode_i <= 1'b0;
    sleep_mode_i       <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr(8'hD8, 8'h01);
    serve(1, 8'($urandom), 1'b0);
    $display("t6 done");
    print_verdict();
  end
endmodule
